//--- cfg_port_defines.vh
// Constants for the converter configuration register port.
// Included by cfg_port.v; definitions only.
`ifndef CFG_PORT_DEFINES_VH
`define CFG_PORT_DEFINES_VH

// ------------------------------------------------------------
// Register layout
// ------------------------------------------------------------
`define CFG_RESET_VAL 8'h10
`define CFG_CMD_MSB 7
`define CFG_CMD_LSB 5
`define CFG_TRIG_BIT 4
`define CFG_BW_BIT 3
`define CFG_SE_BIT 2
`define CFG_ACQ_MSB 1
`define CFG_ACQ_LSB 0

// ------------------------------------------------------------
// Command codes
// ------------------------------------------------------------
`define CMD_STANDBY 3'h0
`define CMD_FULLCAL 3'h1
`define CMD_AUTOZERO 3'h2
`define CMD_IDLE 3'h3
`define CMD_START 3'h4
`define CMD_TEST_A 3'h5
`define CMD_TEST_B 3'h6

// ------------------------------------------------------------
// Acquisition lengths in converter clocks
// ------------------------------------------------------------
`define ACQ_CLK_0 7'h09
`define ACQ_CLK_1 7'h0f
`define ACQ_CLK_2 7'h2f
`define ACQ_CLK_3 7'h4f

`endif

//--- cfg_port.v
// Configuration register port of the sampling converter.
// Assumes host strobes are asynchronous pins, synchronised here to MCLK_I.
`timescale 1ns/1ns
`include "cfg_port_defines.vh"

module cfg_port (
  input wire MCLK_I,
  input wire RESETN_I,
  input wire CS_N_I,
  input wire RD_N_I,
  input wire WR_N_I,
  input wire [7:0] DATA_I,
  output reg CMD_STANDBY_O,
  output reg CMD_FULLCAL_O,
  output reg CMD_AUTOZERO_O,
  output reg CMD_IDLE_O,
  output reg CMD_START_O,
  output reg TRIG_IS_INPUT_O,
  output reg BUS_WIDTH_SEL_O,
  output reg UPPER_DATA_OE_O,
  output reg SINGLE_ENDED_CLAMP_O,
  output reg [1:0] SAMPLE_WINDOW_SEL_O,
  output reg [6:0] SAMPLE_WINDOW_CLKS_O,
  output reg TEST_MODE_O
);

  // ----------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------
  reg [2:0] meta_q;
  reg [2:0] sync_q;
  reg [7:0] data_meta_q;
  reg [7:0] data_sync_q;
  // Strobes reset to their idle high level: no false write
  // follows the release of reset.

  always @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      meta_q <= 3'h7;
      sync_q <= 3'h7;
      data_meta_q <= 8'h00;
      data_sync_q <= 8'h00;
    end else begin
      meta_q <= {CS_N_I, RD_N_I, WR_N_I};
      sync_q <= meta_q;
      data_meta_q <= DATA_I;
      data_sync_q <= data_meta_q;
    end
  end

  wire cs_n = sync_q[2];
  wire rd_n = sync_q[1];
  wire wr_n = sync_q[0];
  // Write data rides two flops of its own, as deep as the strobe path.
  // A write is a selected, low write strobe without read.
  // Reads only block writes and qualify the all_low test-mode lock: no path leads cfg_q to the pins.
  wire wr_act = !cs_n && !wr_n && rd_n;
  wire all_low = !cs_n && !rd_n && !wr_n;

  // ----------------------------------------------------------
  // Write capture and test-mode lock
  // ----------------------------------------------------------
  // One capture per strobe low period. The lock has no exit but
  // the power-on reset, so a stray all-low cycle on a test code
  // costs the user a power cycle.
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_HELD = 2'h1;
  localparam [1:0] ST_LOCK = 2'h2;

  reg [1:0] st_q;
  reg [1:0] st_d;
  reg [7:0] cfg_q;
  reg [7:0] cfg_d;
  wire [2:0] cmd = cfg_q[`CFG_CMD_MSB:`CFG_CMD_LSB];
  wire test_code = (cmd == `CMD_TEST_A) || (cmd == `CMD_TEST_B);
  wire test_hit = all_low && test_code;

  always @* begin
    st_d = st_q;
    cfg_d = cfg_q;
    case (st_q)
      ST_IDLE: begin
        if (test_hit) begin
          st_d = ST_LOCK;
        end else if (wr_act) begin
          cfg_d = data_sync_q;
          st_d = ST_HELD;
        end
      end
      ST_HELD: begin
        // Wait for the strobe to rise before the next capture
        if (test_hit) begin
          st_d = ST_LOCK;
        end else if (!wr_act) begin
          st_d = ST_IDLE;
        end
      end
      ST_LOCK: begin
        // Writes dropped: configuration stays frozen
        st_d = ST_LOCK;
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      st_q <= ST_IDLE;
      cfg_q <= `CFG_RESET_VAL;
    end else begin
      st_q <= st_d;
      cfg_q <= cfg_d;
    end
  end

  // ----------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------
  // Codes 101 to 111 match no entry, so they start nothing.
  localparam N_CMD = 5;
  localparam [14:0] CMD_CODES = {`CMD_START, `CMD_IDLE, `CMD_AUTOZERO,
    `CMD_FULLCAL, `CMD_STANDBY};

  wire [N_CMD-1:0] cmd_hit;

  genvar k;
  generate
    for (k = 0; k < N_CMD; k = k + 1) begin : g_cmd
      assign cmd_hit[k] = (cmd == CMD_CODES[3*k +: 3]);
    end
  endgenerate

  always @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      CMD_STANDBY_O <= 1'b0;
      CMD_FULLCAL_O <= 1'b0;
      CMD_AUTOZERO_O <= 1'b0;
      CMD_IDLE_O <= 1'b0;
      CMD_START_O <= 1'b0;
    end else begin
      CMD_STANDBY_O <= cmd_hit[0];
      CMD_FULLCAL_O <= cmd_hit[1];
      CMD_AUTOZERO_O <= cmd_hit[2];
      CMD_IDLE_O <= cmd_hit[3];
      CMD_START_O <= cmd_hit[4];
    end
  end

  // ----------------------------------------------------------
  // Trigger direction, bus width and clamp
  // ----------------------------------------------------------
  // The upper-line enable follows the width bit; a flop of its
  // own lets the pad ring take it with no logic in between.
  always @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      TRIG_IS_INPUT_O <= 1'b0;
      BUS_WIDTH_SEL_O <= 1'b0;
      UPPER_DATA_OE_O <= 1'b0;
      SINGLE_ENDED_CLAMP_O <= 1'b0;
    end else begin
      TRIG_IS_INPUT_O <= cfg_q[`CFG_TRIG_BIT];
      BUS_WIDTH_SEL_O <= cfg_q[`CFG_BW_BIT];
      UPPER_DATA_OE_O <= cfg_q[`CFG_BW_BIT];
      SINGLE_ENDED_CLAMP_O <= cfg_q[`CFG_SE_BIT];
    end
  end

  // ----------------------------------------------------------
  // Acquisition window
  // ----------------------------------------------------------
  // Lengths count converter clocks; they only matter while the
  // trigger pin is an output.
  reg [6:0] acq_d;

  always @* begin
    case (cfg_q[`CFG_ACQ_MSB:`CFG_ACQ_LSB])
      2'h0: acq_d = `ACQ_CLK_0;
      2'h1: acq_d = `ACQ_CLK_1;
      2'h2: acq_d = `ACQ_CLK_2;
      default: acq_d = `ACQ_CLK_3;
    endcase
  end

  always @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      SAMPLE_WINDOW_SEL_O <= 2'h0;
      SAMPLE_WINDOW_CLKS_O <= 7'h00;
    end else begin
      SAMPLE_WINDOW_SEL_O <= cfg_q[`CFG_ACQ_MSB:`CFG_ACQ_LSB];
      SAMPLE_WINDOW_CLKS_O <= acq_d;
    end
  end

  // ----------------------------------------------------------
  // Test-mode flag
  // ----------------------------------------------------------
  // Follows the lock state one clock later; it never falls
  // until the power-on reset clears the lock.
  always @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      TEST_MODE_O <= 1'b0;
    end else begin
      TEST_MODE_O <= (st_q == ST_LOCK);
    end
  end

endmodule

//--- cfg_port_host.sv
// Host model driving chip-select, strobes and write data.
// Moves on falling edges; each phase stands four clocks.
`timescale 1ns/1ns
module cfg_port_host (input wire clk_i, output reg cs_n_o, rd_n_o,
  wr_n_o, output reg [7:0] data_o);
  initial {cs_n_o, rd_n_o, wr_n_o, data_o} = 11'h700;
  task cyc(input [2:0] lo, input [7:0] v);
    begin
      @(negedge clk_i) {cs_n_o, rd_n_o, wr_n_o, data_o} = {~lo, v};
      repeat (4) @(negedge clk_i);
      {cs_n_o, rd_n_o, wr_n_o, data_o} = {3'h7, ~v}; // Bus let go
      repeat (4) @(negedge clk_i);
    end
  endtask
endmodule

//--- cfg_port_checker.sv
// Checker on the configuration port outputs.
// Bound to cfg_port; sees only its ports.
`timescale 1ns/1ns
module cfg_port_checker (input wire MCLK_I, RESETN_I, CS_N_I, RD_N_I,
  WR_N_I, CMD_STANDBY_O, CMD_FULLCAL_O, CMD_AUTOZERO_O, CMD_IDLE_O,
  CMD_START_O, TRIG_IS_INPUT_O, BUS_WIDTH_SEL_O, UPPER_DATA_OE_O,
  TEST_MODE_O, input wire [1:0] SAMPLE_WINDOW_SEL_O,
  input wire [6:0] SAMPLE_WINDOW_CLKS_O);
  wire [4:0] cmd = {CMD_START_O, CMD_IDLE_O, CMD_AUTOZERO_O,
    CMD_FULLCAL_O, CMD_STANDBY_O};
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RESETN_I);
  a_reset_value: assert property (!$past(RESETN_I) |=> cmd == 5'h01 &&
    TRIG_IS_INPUT_O && SAMPLE_WINDOW_CLKS_O == 7'h09) else $error("reset");
  a_cmd_onehot: assert property ($onehot0(cmd)) else $error("decode");
  a_upper_oe: assert property (UPPER_DATA_OE_O == BUS_WIDTH_SEL_O)
    else $error("upper enable");
  a_window_max: assert property ($past(RESETN_I) &&
    SAMPLE_WINDOW_SEL_O == 2'h3 |-> SAMPLE_WINDOW_CLKS_O == 7'h4f)
    else $error("window");
  a_test_stays: assert property (TEST_MODE_O |=> TEST_MODE_O)
    else $error("test left");
  a_test_frozen: assert property (TEST_MODE_O |=> $stable(cmd))
    else $error("test write");
  a_test_entry: assert property ($rose(TEST_MODE_O) |-> cmd == 5'h00 &&
    !$past(CS_N_I, 4) && !$past(RD_N_I, 4) && !$past(WR_N_I, 4))
    else $error("test entry");
  a_write_only: assert property ($past(RESETN_I, 2) &&
    $changed(BUS_WIDTH_SEL_O) |-> !$past(WR_N_I, 3) || !$past(WR_N_I, 4))
    else $error("no write");
endmodule
bind cfg_port cfg_port_checker i_chk (.*);

//--- cfg_port_bench.sv
// Bench: reset value, every field and command, a read, test mode.
// Host model makes the bus cycles; outputs checked as one vector.
`timescale 1ns/1ns
module cfg_port_bench;
  reg clk = 1'b0, rst_n = 1'b0;
  integer err_count = 0, n_compared = 0, c;
  wire cs_n, rd_n, wr_n;
  wire [7:0] d;
  wire [18:0] o;
  always #10 clk = ~clk;
  cfg_port_host i_host (.clk_i(clk), .cs_n_o(cs_n), .rd_n_o(rd_n),
    .wr_n_o(wr_n), .data_o(d));
  cfg_port i_dut (.MCLK_I(clk), .RESETN_I(rst_n), .CS_N_I(cs_n),
    .RD_N_I(rd_n), .WR_N_I(wr_n), .DATA_I(d), .CMD_STANDBY_O(o[14]),
    .CMD_FULLCAL_O(o[15]), .CMD_AUTOZERO_O(o[16]), .CMD_IDLE_O(o[17]),
    .CMD_START_O(o[18]), .TRIG_IS_INPUT_O(o[13]), .BUS_WIDTH_SEL_O(o[12]),
    .UPPER_DATA_OE_O(o[11]), .SINGLE_ENDED_CLAMP_O(o[10]),
    .SAMPLE_WINDOW_SEL_O(o[9:8]), .SAMPLE_WINDOW_CLKS_O(o[7:1]),
    .TEST_MODE_O(o[0]));
  task chk(input [7:0] v, input t);
    reg [6:0] w;
    begin
      w = v[1] ? (v[0] ? 7'h4f : 7'h2f) : (v[0] ? 7'h0f : 7'h09);
      n_compared = n_compared + 1;
      if (o !== {5'h01 << v[7:5], v[4:3], v[3:0], w, t}) begin
        err_count = err_count + 1;
        $display("unexpected at %0t: outputs %h", $time, o);
      end
    end
  endtask
  task results;
    begin
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task do_reset;
    begin
      rst_n = 1'b0;
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
      chk(8'h10, 1'b0);
    end
  endtask
  task t_test(input [2:0] k, input t);
    begin
      i_host.cyc(3'h5, {k, 5'h0b});
      i_host.cyc(3'h7, 8'h00);
      chk({k, 5'h0b}, t);
      i_host.cyc(3'h5, 8'h9c);
      chk(t ? {k, 5'h0b} : 8'h9c, t);
    end
  endtask
  task t_fields;
    begin
      for (c = 0; c < 8; c = c + 1) begin
        i_host.cyc(3'h5, {c[2:0], c[0], c[1], c[2], c[1:0]});
        chk({c[2:0], c[0], c[1], c[2], c[1:0]}, 1'b0);
      end
    end
  endtask
  task t_read;
    begin
      i_host.cyc(3'h6, 8'h00);
      chk(8'hff, 1'b0);
    end
  endtask
  initial begin
    repeat (900) @(posedge clk);
    err_count = err_count + 1;
    results;
  end
  initial begin
    do_reset;
    t_fields;
    t_read;
    t_test(3'h4, 1'b0);
    t_test(3'h5, 1'b1);
    do_reset;
    t_test(3'h6, 1'b1);
    results;
  end
endmodule
